// File: verilog/rcio_pkg.sv
package rcio_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int TONE_HZ = 900;
  localparam int TONE_HALF = CLK_HZ / (2 * TONE_HZ);
  localparam int HANG_SHORT_MS = 150;
  localparam int HANG_LONG_MS = 500;
  localparam int HANG_SHORT = (CLK_HZ / 1000) * HANG_SHORT_MS;
  localparam int HANG_LONG = (CLK_HZ / 1000) * HANG_LONG_MS;
  localparam int BAUD = 9600;
  localparam int BAUD_DIV = CLK_HZ / BAUD;
  localparam int SCAN_DIV = 125_000;
  localparam logic [2:0] DEB_SCANS = 3'h4;
  localparam logic [7:0] SCK_HALF = 8'h08;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TONE = 8'h04;
  localparam logic [7:0] OFS_SER_DATA = 8'h08;
  localparam logic [7:0] OFS_SER_CMD = 8'h0c;
  localparam logic [7:0] OFS_DISP = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_UART = 8'h18;

  // Control register bit positions.
  localparam int CB_HANG_LONG = 0;
  localparam int CB_FULL_EN = 1;
  localparam int CB_RX_LOW = 2;
  localparam int CB_RX_HIGH = 3;
  localparam int CB_CALL_TX = 4;
  localparam int CB_ALERT = 5;
  localparam int CB_ALARM = 6;
  localparam int CB_LAMP = 7;
  localparam int CB_SQUELCH = 8;
  localparam int CB_CALL_MUTE = 9;
  localparam int CB_MON_KEY = 10;
  localparam logic [10:0] CTRL_RST = 11'h080;

  // Serial command fields and targets.
  localparam int SC_NBITS_LSB = 0;
  localparam int SC_TGT_LSB = 5;
  localparam logic [1:0] TGT_LOOP_A = 2'h0;
  localparam logic [1:0] TGT_LOOP_B = 2'h1;
  localparam logic [1:0] TGT_LOOP_C = 2'h2;
  localparam logic [1:0] TGT_SHREG = 2'h3;

  // Display register fields.
  localparam int DB_CMD = 8;
  localparam int DB_DRV2 = 9;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } rcio_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rcio_apb_rsp_t;

  typedef struct packed {
    logic mosi;
    logic sck;
    logic loop_a_latch;
    logic loop_b_latch;
    logic loop_c_latch;
    logic shreg_load_select;
    logic spi_busy_out;
  } rcio_ser_t;

endpackage

// File: verilog/rcio_top.sv
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module rcio_top #(
  parameter int TONE_HALF = rcio_pkg::TONE_HALF,
  parameter int HANG_SHORT = rcio_pkg::HANG_SHORT,
  parameter int HANG_LONG = rcio_pkg::HANG_LONG,
  parameter int BAUD_DIV = rcio_pkg::BAUD_DIV,
  parameter int SCAN_DIV = rcio_pkg::SCAN_DIV
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus
  input wire rcio_pkg::rcio_apb_req_t apb_req,
  output rcio_pkg::rcio_apb_rsp_t apb_rsp,
  // Keyboard columns and display write lines
  output logic [3:0] col_out,
  input wire logic [3:0] row_in,
  output logic [3:0] row_out,
  output logic [3:0] row_oe,
  input wire logic driver_full_in,
  // Synthesizer and shift register serial bus
  output rcio_pkg::rcio_ser_t ser,
  // Selective calling, Morse and monitor lines
  output logic rx_lowgain_sel,
  output logic rx_highgain_sel,
  output logic tx_key_out,
  output logic tone_out,
  output logic sidetone_enable,
  output logic power_limit_out,
  output logic monitor_lamp_mute,
  output logic ext_alarm_out,
  output logic squelch_ctl,
  output logic synth_silence,
  input wire logic morse_key_in,
  input wire logic monitor_request,
  // Computer interface
  output logic txd,
  input wire logic rxd
);

  typedef enum logic [1:0] {SER_IDLE, SER_LOW, SER_HIGH, SER_LATCH} rcio_ser_st_t;
  typedef enum logic [1:0] {DSP_IDLE, DSP_WAIT, DSP_LOW, DSP_HIGH} rcio_dsp_st_t;

  typedef struct packed {
    logic [10:0] ctrl;
    logic [7:0] duty;
    logic [7:0] pwm_cnt;
    logic [31:0] prdata;
    logic perr;
    logic [3:0] row_s1;
    logic [3:0] row_s2;
    logic [1:0] full_s;
    logic [1:0] key_s;
    logic [1:0] mon_s;
    logic [1:0] rxd_s;
    logic [31:0] scan_div;
    logic [1:0] col_idx;
    logic [11:0] sweep;
    logic [11:0] prev;
    logic [11:0] keys;
    logic [2:0] deb;
    rcio_ser_st_t ser_st;
    logic [23:0] ser_data;
    logic [23:0] ser_sh;
    logic [4:0] ser_cnt;
    logic [1:0] ser_tgt;
    logic [7:0] ser_div;
    rcio_dsp_st_t dsp_st;
    logic [7:0] dsp_sh;
    logic [3:0] dsp_cnt;
    logic dsp_cmd;
    logic dsp_drv2;
    logic [7:0] dsp_div;
    logic key_deb;
    logic [2:0] key_cnt;
    logic morse_tx;
    logic [31:0] hang_cnt;
    logic [31:0] tone_cnt;
    logic tone_sq;
    logic [9:0] tx_sh;
    logic [3:0] tx_bits;
    logic [31:0] tx_div;
    logic rx_on;
    logic [3:0] rx_bits;
    logic [31:0] rx_div;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic rx_valid;
  } rcio_state_t;

  rcio_state_t s_reg;
  rcio_state_t s_next;
  logic setup_ph;
  logic access_ph;
  logic wr;
  logic scan_tick;
  logic dsp_busy;
  logic key_down;
  logic pwm_o;
  logic ext_mon;
  logic [11:0] swp;
  logic [31:0] hang_lim;

  // --------------------------------------------------
  // Bus phases and shared decodes
  // --------------------------------------------------
  assign setup_ph = apb_req.psel & ~apb_req.penable;
  assign access_ph = apb_req.psel & apb_req.penable;
  assign wr = access_ph & apb_req.pwrite & ~s_reg.perr;
  assign scan_tick = (s_reg.scan_div == 32'(SCAN_DIV - 1));
  assign dsp_busy = (s_reg.dsp_st != DSP_IDLE);
  assign key_down = s_reg.morse_tx & ~s_reg.key_deb;
  assign pwm_o = (s_reg.pwm_cnt < s_reg.duty);
  assign ext_mon = s_reg.mon_s[1];
  assign hang_lim = s_reg.ctrl[rcio_pkg::CB_HANG_LONG] ? 32'(HANG_LONG) : 32'(HANG_SHORT);

  // --------------------------------------------------
  // Next state
  // --------------------------------------------------
  // Every engine lives in one state record so that reset and update stay in one place.
  always_comb begin
    s_next = s_reg;
    swp = s_reg.sweep;
    // Two-stage synchronisers for every pin input.
    s_next.row_s1 = row_in;
    s_next.row_s2 = s_reg.row_s1;
    s_next.full_s = {s_reg.full_s[0], driver_full_in};
    s_next.key_s = {s_reg.key_s[0], morse_key_in};
    s_next.mon_s = {s_reg.mon_s[0], monitor_request};
    s_next.rxd_s = {s_reg.rxd_s[0], rxd};
    s_next.pwm_cnt = s_reg.pwm_cnt + 8'h01;
    s_next.scan_div = scan_tick ? 32'h0000_0000 : s_reg.scan_div + 32'h0000_0001;

    // Read data is prepared in the setup cycle so it comes from a flop in the access cycle.
    if (setup_ph) begin
      s_next.perr = 1'b0;
      s_next.prdata = 32'h0000_0000;
      unique case (apb_req.paddr)
        rcio_pkg::OFS_CTRL: s_next.prdata = 32'(s_reg.ctrl);
        rcio_pkg::OFS_TONE: s_next.prdata = 32'(s_reg.duty);
        rcio_pkg::OFS_SER_DATA: s_next.prdata = 32'(s_reg.ser_data);
        rcio_pkg::OFS_SER_CMD: s_next.prdata = 32'({s_reg.ser_tgt, s_reg.ser_cnt});
        rcio_pkg::OFS_DISP: s_next.prdata = 32'({s_reg.dsp_drv2, s_reg.dsp_cmd, s_reg.dsp_sh});
        rcio_pkg::OFS_STATUS: s_next.prdata = 32'({s_reg.full_s[1], sidetone_enable, s_reg.morse_tx,
                                                   dsp_busy, ser.spi_busy_out, s_reg.keys});
        rcio_pkg::OFS_UART: s_next.prdata = 32'({(s_reg.tx_bits != 4'h0), s_reg.rx_valid, s_reg.rx_data});
        default: s_next.perr = 1'b1;
      endcase
    end

    // Register writes; a write to a running engine's start register is ignored.
    if (wr) begin
      unique case (apb_req.paddr)
        rcio_pkg::OFS_CTRL: s_next.ctrl = apb_req.pwdata[10:0];
        rcio_pkg::OFS_TONE: s_next.duty = apb_req.pwdata[7:0];
        rcio_pkg::OFS_SER_DATA: s_next.ser_data = apb_req.pwdata[23:0];
        default: ;
      endcase
    end

    // Keyboard scan pauses while the column lines carry display traffic.
    if (scan_tick && !dsp_busy) begin
      swp[{s_reg.col_idx, 2'b00} - {2'b00, s_reg.col_idx} +: 3] = s_reg.row_s2[2:0];
      s_next.sweep = swp;
      s_next.col_idx = s_reg.col_idx + 2'h1;
      if (s_reg.col_idx == 2'h3) begin
        // A new key map is accepted only after identical full sweeps.
        s_next.prev = swp;
        if (swp != s_reg.prev) begin
          s_next.deb = 3'h0;
        end else if (s_reg.deb == rcio_pkg::DEB_SCANS - 3'h1) begin
          s_next.keys = swp;
        end else begin
          s_next.deb = s_reg.deb + 3'h1;
        end
      end
    end

    // Display writer: one byte per request, bit by bit, stalled by a full driver.
    unique case (s_reg.dsp_st)
      DSP_IDLE: begin
        if (wr && apb_req.paddr == rcio_pkg::OFS_DISP) begin
          s_next.dsp_sh = apb_req.pwdata[7:0];
          s_next.dsp_cmd = apb_req.pwdata[rcio_pkg::DB_CMD];
          s_next.dsp_drv2 = apb_req.pwdata[rcio_pkg::DB_DRV2];
          s_next.dsp_cnt = 4'h8;
          s_next.dsp_st = DSP_WAIT;
        end
      end
      DSP_WAIT: begin
        s_next.dsp_div = 8'h00;
        if (!(s_reg.ctrl[rcio_pkg::CB_FULL_EN] && s_reg.full_s[1])) begin
          s_next.dsp_st = DSP_LOW;
        end
      end
      DSP_LOW: begin
        s_next.dsp_div = s_reg.dsp_div + 8'h01;
        if (s_reg.dsp_div == rcio_pkg::SCK_HALF - 8'h01) begin
          s_next.dsp_div = 8'h00;
          s_next.dsp_st = DSP_HIGH;
        end
      end
      DSP_HIGH: begin
        s_next.dsp_div = s_reg.dsp_div + 8'h01;
        if (s_reg.dsp_div == rcio_pkg::SCK_HALF - 8'h01) begin
          s_next.dsp_sh = {s_reg.dsp_sh[6:0], 1'b0};
          s_next.dsp_cnt = s_reg.dsp_cnt - 4'h1;
          s_next.dsp_st = (s_reg.dsp_cnt == 4'h1) ? DSP_IDLE : DSP_WAIT;
        end
      end
    endcase

    // Serial master: word shifts MSB first, then exactly one target strobe.
    unique case (s_reg.ser_st)
      SER_IDLE: begin
        s_next.ser_div = 8'h00;
        if (wr && apb_req.paddr == rcio_pkg::OFS_SER_CMD) begin
          s_next.ser_cnt = apb_req.pwdata[rcio_pkg::SC_NBITS_LSB +: 5];
          s_next.ser_tgt = apb_req.pwdata[rcio_pkg::SC_TGT_LSB +: 2];
          s_next.ser_sh = s_reg.ser_data << (5'd23 - apb_req.pwdata[rcio_pkg::SC_NBITS_LSB +: 5]);
          s_next.ser_st = SER_LOW;
        end
      end
      SER_LOW: begin
        s_next.ser_div = s_reg.ser_div + 8'h01;
        if (s_reg.ser_div == rcio_pkg::SCK_HALF - 8'h01) begin
          s_next.ser_div = 8'h00;
          s_next.ser_st = SER_HIGH;
        end
      end
      SER_HIGH: begin
        s_next.ser_div = s_reg.ser_div + 8'h01;
        if (s_reg.ser_div == rcio_pkg::SCK_HALF - 8'h01) begin
          s_next.ser_div = 8'h00;
          s_next.ser_sh = {s_reg.ser_sh[22:0], 1'b0};
          s_next.ser_cnt = s_reg.ser_cnt - 5'h01;
          s_next.ser_st = (s_reg.ser_cnt == 5'h00) ? SER_LATCH : SER_LOW;
        end
      end
      SER_LATCH: begin
        s_next.ser_div = s_reg.ser_div + 8'h01;
        if (s_reg.ser_div == rcio_pkg::SCK_HALF - 8'h01) begin
          s_next.ser_st = SER_IDLE;
        end
      end
    endcase

    // Morse key debounce on scan ticks; a change must persist for several ticks.
    if (scan_tick) begin
      if (s_reg.key_s[1] == s_reg.key_deb) begin
        s_next.key_cnt = 3'h0;
      end else if (s_reg.key_cnt == rcio_pkg::DEB_SCANS - 3'h1) begin
        s_next.key_deb = s_reg.key_s[1];
        s_next.key_cnt = 3'h0;
      end else begin
        s_next.key_cnt = s_reg.key_cnt + 3'h1;
      end
    end

    // Morse keying with tone while down and a hang timer once released.
    if (!s_reg.key_deb) begin
      s_next.morse_tx = 1'b1;
      s_next.hang_cnt = 32'h0000_0000;
    end else if (s_reg.morse_tx) begin
      s_next.hang_cnt = s_reg.hang_cnt + 32'h0000_0001;
      if (s_reg.hang_cnt == hang_lim) begin
        s_next.morse_tx = 1'b0;
      end
    end
    if (key_down) begin
      s_next.tone_cnt = s_reg.tone_cnt + 32'h0000_0001;
      if (s_reg.tone_cnt == 32'(TONE_HALF - 1)) begin
        s_next.tone_cnt = 32'h0000_0000;
        s_next.tone_sq = ~s_reg.tone_sq;
      end
    end else begin
      s_next.tone_cnt = 32'h0000_0000;
      s_next.tone_sq = 1'b0;
    end

    // Asynchronous serial transmitter, 8N1, idle high.
    if (s_reg.tx_bits == 4'h0) begin
      if (wr && apb_req.paddr == rcio_pkg::OFS_UART) begin
        s_next.tx_sh = {1'b1, apb_req.pwdata[7:0], 1'b0};
        s_next.tx_bits = 4'ha;
        s_next.tx_div = 32'h0000_0000;
      end
    end else begin
      s_next.tx_div = s_reg.tx_div + 32'h0000_0001;
      if (s_reg.tx_div == 32'(BAUD_DIV - 1)) begin
        s_next.tx_div = 32'h0000_0000;
        s_next.tx_sh = {1'b1, s_reg.tx_sh[9:1]};
        s_next.tx_bits = s_reg.tx_bits - 4'h1;
      end
    end

    // Receiver samples mid-bit. A read clears the valid flag only when it returned it set, so a byte that
    // lands during the setup cycle is not lost; the clear comes first so a byte landing now still sets it.
    if (access_ph && !apb_req.pwrite && !s_reg.perr && apb_req.paddr == rcio_pkg::OFS_UART &&
        s_reg.prdata[8]) begin
      s_next.rx_valid = 1'b0;
    end
    if (!s_reg.rx_on) begin
      if (!s_reg.rxd_s[1]) begin
        s_next.rx_on = 1'b1;
        s_next.rx_bits = 4'h0;
        s_next.rx_div = 32'(BAUD_DIV / 2);
      end
    end else if (s_reg.rx_div == 32'h0000_0000) begin
      s_next.rx_div = 32'(BAUD_DIV - 1);
      s_next.rx_bits = s_reg.rx_bits + 4'h1;
      if (s_reg.rx_bits == 4'h0) begin
        s_next.rx_on = ~s_reg.rxd_s[1];
      end else if (s_reg.rx_bits == 4'h9) begin
        s_next.rx_on = 1'b0;
        if (s_reg.rxd_s[1]) begin
          s_next.rx_data = s_reg.rx_sh;
          s_next.rx_valid = 1'b1;
        end
      end else begin
        s_next.rx_sh = {s_reg.rxd_s[1], s_reg.rx_sh[7:1]};
      end
    end else begin
      s_next.rx_div = s_reg.rx_div - 32'h0000_0001;
    end
  end

  // --------------------------------------------------
  // State register
  // --------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.ctrl <= rcio_pkg::CTRL_RST;
      s_reg.key_s <= 2'b11;
      s_reg.rxd_s <= 2'b11;
      s_reg.key_deb <= 1'b1;
      s_reg.tx_sh <= 10'h3ff;
      s_reg.ser_st <= SER_IDLE;
      s_reg.dsp_st <= DSP_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // --------------------------------------------------
  // Outputs
  // --------------------------------------------------
  // Zero wait states: the access phase always completes.
  assign apb_rsp.pready = access_ph;
  assign apb_rsp.prdata = s_reg.prdata;
  assign apb_rsp.pslverr = s_reg.perr;

  // Columns: one-hot scan strobe, or display command, strobes and data while writing.
  always_comb begin
    if (dsp_busy) begin
      col_out[0] = s_reg.dsp_cmd;
      col_out[1] = (s_reg.dsp_st == DSP_HIGH) & s_reg.dsp_drv2;
      col_out[2] = (s_reg.dsp_st == DSP_HIGH) & ~s_reg.dsp_drv2;
      col_out[3] = s_reg.dsp_sh[7];
    end else begin
      col_out = 4'h1 << s_reg.col_idx;
    end
  end
  // Rows are only driven, to zero, while the columns carry display traffic.
  assign row_out = 4'h0;
  assign row_oe = {4{dsp_busy}};

  // The bus is never released to outside processors; they may only listen.
  assign ser.mosi = s_reg.ser_sh[23];
  assign ser.sck = (s_reg.ser_st == SER_HIGH);
  assign ser.loop_a_latch = (s_reg.ser_st == SER_LATCH) & (s_reg.ser_tgt == rcio_pkg::TGT_LOOP_A);
  assign ser.loop_b_latch = (s_reg.ser_st == SER_LATCH) & (s_reg.ser_tgt == rcio_pkg::TGT_LOOP_B);
  assign ser.loop_c_latch = (s_reg.ser_st == SER_LATCH) & (s_reg.ser_tgt == rcio_pkg::TGT_LOOP_C);
  assign ser.shreg_load_select = (s_reg.ser_st == SER_LATCH) & (s_reg.ser_tgt == rcio_pkg::TGT_SHREG);
  assign ser.spi_busy_out = (s_reg.ser_st != SER_IDLE);

  // Audio routing, keying and tone selection; Morse tone has priority over the PWM tone.
  assign rx_lowgain_sel = ~s_reg.ctrl[rcio_pkg::CB_RX_LOW];
  assign rx_highgain_sel = ~s_reg.ctrl[rcio_pkg::CB_RX_HIGH];
  assign tx_key_out = s_reg.morse_tx | s_reg.ctrl[rcio_pkg::CB_CALL_TX] | s_reg.ctrl[rcio_pkg::CB_ALERT];
  assign tone_out = key_down ? s_reg.tone_sq : (pwm_o & (s_reg.ctrl[rcio_pkg::CB_CALL_TX] |
                    s_reg.ctrl[rcio_pkg::CB_ALERT]));
  assign sidetone_enable = s_reg.morse_tx | s_reg.ctrl[rcio_pkg::CB_ALERT];
  assign power_limit_out = s_reg.morse_tx;
  assign ext_alarm_out = s_reg.ctrl[rcio_pkg::CB_ALARM];

  // Monitor overrides: the external request lifts the squelch and the calling mute, the panel key the lamp mute and the calling mute.
  assign monitor_lamp_mute = s_reg.ctrl[rcio_pkg::CB_LAMP] & ~s_reg.ctrl[rcio_pkg::CB_MON_KEY];
  assign squelch_ctl = s_reg.ctrl[rcio_pkg::CB_SQUELCH] & ~ext_mon;
  assign synth_silence = s_reg.ctrl[rcio_pkg::CB_CALL_MUTE] & ~ext_mon &
                         ~s_reg.ctrl[rcio_pkg::CB_MON_KEY];
  assign txd = s_reg.tx_sh[0];

endmodule

// File: verif/rcio_ser_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Loop dividers and board shift registers
// ----------------------------------------
module rcio_ser_model (
  // Clock and serial bus
  input wire logic clk_sys,
  input wire rcio_pkg::rcio_ser_t ser,
  // Last loaded word, its target and the number of loads
  output logic [23:0] word,
  output logic [1:0] tgt,
  output int loads
);
  logic [23:0] sh;
  logic [3:0] lat;
  logic [3:0] lat_q;
  logic sck_q;
  assign lat = {ser.shreg_load_select, ser.loop_c_latch, ser.loop_b_latch, ser.loop_a_latch};
  initial begin
    {sh, word, tgt, lat_q, sck_q} = '0;
    loads = 0;
  end
  // Targets only listen and never drive back; a rising latch takes the shifted word.
  always @(posedge clk_sys) begin
    sck_q <= ser.sck;
    lat_q <= lat;
    if (ser.sck && !sck_q) sh <= {sh[22:0], ser.mosi};
    if ((lat & ~lat_q) != 4'h0) begin
      word <= sh;
      tgt <= lat[1] ? 2'h1 : lat[2] ? 2'h2 : lat[3] ? 2'h3 : 2'h0;
      loads <= loads + 1;
    end
  end
endmodule

// File: verif/rcio_top_chk.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checks of the control sequencer
// ----------------------------------------
module rcio_top_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Watched ports
  input wire rcio_pkg::rcio_apb_req_t apb_req,
  input wire rcio_pkg::rcio_apb_rsp_t apb_rsp,
  input wire logic [3:0] col_out,
  input wire logic [3:0] row_out,
  input wire logic [3:0] row_oe,
  input wire rcio_pkg::rcio_ser_t ser,
  input wire logic tx_key_out,
  input wire logic tone_out,
  input wire logic sidetone_enable,
  input wire logic power_limit_out
);
  logic [3:0] tgt;
  // All latch and select lines, watched as one group.
  assign tgt = {ser.shreg_load_select, ser.loop_c_latch, ser.loop_b_latch, ser.loop_a_latch};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_ready; apb_req.psel && apb_req.penable |-> apb_rsp.pready; endproperty
  a_ready: assert property (p_ready) else $error("pready missing in access cycle");
  property p_scan; row_oe == 4'h0 |-> $onehot(col_out); endproperty
  a_scan: assert property (p_scan) else $error("scan columns not one-hot");
  property p_rows; row_oe != 4'h0 |-> row_oe == 4'hf && row_out == 4'h0; endproperty
  a_rows: assert property (p_rows) else $error("rows not all driven to zero");
  property p_one; $onehot0(tgt); endproperty
  a_one: assert property (p_one) else $error("more than one target selected");
  property p_pulse; $rose(|tgt) |-> (|tgt) [*8] ##1 !(|tgt); endproperty
  a_pulse: assert property (p_pulse) else $error("target pulse length wrong");
  property p_busy; (|tgt) || ser.sck |-> ser.spi_busy_out; endproperty
  a_busy: assert property (p_busy) else $error("serial activity without busy");
  property p_mosi; ser.sck && $past(ser.sck) |-> $stable(ser.mosi); endproperty
  a_mosi: assert property (p_mosi) else $error("mosi moved while sck high");
  property p_hang; $fell(tx_key_out) |-> !sidetone_enable && !power_limit_out; endproperty
  a_hang: assert property (p_hang) else $error("sidetone or limit left on");
  property p_tone; $rose(tone_out) |-> tx_key_out; endproperty
  a_tone: assert property (p_tone) else $error("tone without transmit");
  property p_lim; power_limit_out |-> tx_key_out && sidetone_enable; endproperty
  a_lim: assert property (p_lim) else $error("limit without keying");
  c_loop: cover property ($rose(ser.loop_c_latch));
  c_drop: cover property ($fell(tx_key_out));
  c_disp: cover property ($rose(row_oe[0]));
endmodule
bind rcio_top rcio_top_chk u_rcio_top_chk (.clk_sys, .rst_n, .apb_req, .apb_rsp, .col_out, .row_out, .row_oe,
  .ser, .tx_key_out, .tone_out, .sidetone_enable, .power_limit_out);

// File: verif/rcio_top_test.sv
`timescale 1ns/100ps
// ----------------------------------------
// Bench of the control sequencer
// ----------------------------------------
module rcio_top_test;
  localparam int HS = 100;
  localparam int HL = 300;
  localparam int SD = 16;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  rcio_pkg::rcio_apb_req_t apb_req = '0;
  rcio_pkg::rcio_apb_rsp_t apb_rsp;
  rcio_pkg::rcio_ser_t ser;
  logic [3:0] col_out, row_out, row_oe, pc;
  logic [3:0] row_in = 4'h0;
  logic driver_full_in = 1'b0, morse_key_in = 1'b1, monitor_request = 1'b0;
  logic rx_lowgain_sel, rx_highgain_sel, tx_key_out, tone_out, sidetone_enable, power_limit_out;
  logic monitor_lamp_mute, ext_alarm_out, squelch_ctl, synth_silence, txd, err, m, key_on = 1'b0, dc;
  logic [23:0] word;
  logic [1:0] tgt, ds;
  logic [7:0] dbits, e;
  logic [31:0] rd, v;
  logic [7:0] uq[$];
  int loads, bad_count = 0, num_checks = 0, n, t, i, nb, kc, kr, dn = 0;
  rcio_top #(.TONE_HALF(8), .HANG_SHORT(HS), .HANG_LONG(HL), .BAUD_DIV(16), .SCAN_DIV(SD)) u_rcio_top (
    .clk_sys, .rst_n, .apb_req, .apb_rsp, .col_out, .row_in, .row_out, .row_oe, .driver_full_in, .ser,
    .rx_lowgain_sel, .rx_highgain_sel, .tx_key_out, .tone_out, .sidetone_enable, .power_limit_out,
    .monitor_lamp_mute, .ext_alarm_out, .squelch_ctl, .synth_silence, .morse_key_in, .monitor_request,
    .txd, .rxd(txd));
  rcio_ser_model u_rcio_ser_model (.clk_sys, .ser, .word, .tgt, .loads);
  initial forever #4 clk_sys = ~clk_sys;
  // The key matrix answers one cycle after its column is driven, like a slow decoder.
  always @(posedge clk_sys) row_in <= (key_on && col_out == (4'h1 << kc)) ? (4'h1 << kr) : 4'h0;
  // Display bits are taken at each strobe rise, as the driver would clock them.
  always @(posedge clk_sys) begin
    pc <= col_out;
    if (row_oe == 4'hf && (col_out[2:1] & ~pc[2:1]) != 2'h0) begin
      dbits <= {dbits[6:0], col_out[3]};
      ds <= col_out[2:1];
      dc <= col_out[0];
      dn <= dn + 1;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // A wait that ran out is a mismatch and closes the run.
  task automatic lim(input int used, input int max);
    if (used >= max) begin
      check("wait", 0, 1);
      end_of_test();
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    lim(n, 50);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  initial begin
    void'($urandom(32'h3593));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(0, rcio_pkg::OFS_CTRL, 0);
    check("ctrl reset", rd, 32'h080);
    check("idle lines", {rx_lowgain_sel, rx_highgain_sel, monitor_lamp_mute, tx_key_out, ext_alarm_out}, 5'h1c);
    apb(0, 8'h1c, 0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    for (i = 0; i < 8; i++) begin
      v = $urandom & 32'h7ff;
      m = $urandom % 2;
      monitor_request <= m;
      apb(1, rcio_pkg::OFS_CTRL, v);
      repeat (4) @(posedge clk_sys);
      e = {!v[2], !v[3], v[6], v[7] & !v[10], v[8] & !m, v[9] & !m & !v[10], v[4] | v[5], v[5]};
      check("ctrl lines", {rx_lowgain_sel, rx_highgain_sel, ext_alarm_out, monitor_lamp_mute, squelch_ctl,
        synth_silence, tx_key_out, sidetone_enable}, e);
    end
    monitor_request <= 1'b0;
    // The free PWM counter spans 256 cycles, so any such window holds exactly duty high cycles.
    v = $urandom & 32'hff;
    apb(1, rcio_pkg::OFS_TONE, v);
    apb(1, rcio_pkg::OFS_CTRL, 32'h090);
    kr = 0;
    repeat (256) begin
      @(posedge clk_sys);
      if (tone_out === 1'b1) kr++;
    end
    check("pwm duty", kr, v);
    apb(1, rcio_pkg::OFS_CTRL, 32'h080);
    for (i = 0; i < 4; i++) begin
      v = $urandom & 32'hffffff;
      nb = (i == 0) ? 24 : 1 + $urandom % 24;
      apb(1, rcio_pkg::OFS_SER_DATA, v);
      apb(1, rcio_pkg::OFS_SER_CMD, (i << 5) | (nb - 1));
      apb(1, rcio_pkg::OFS_SER_CMD, ((i ^ 1) << 5) | 3);
      check("busy", ser.spi_busy_out, 1);
      for (t = 0; t < 600 && ser.spi_busy_out; t++) @(posedge clk_sys);
      lim(t, 600);
      check("word", word & ((1 << nb) - 1), v & ((1 << nb) - 1));
      check("target", {tgt, loads[7:0]}, {i[1:0], 8'(i + 1)});
    end
    kc = $urandom % 4;
    kr = $urandom % 3;
    key_on = 1'b1;
    repeat (600) @(posedge clk_sys);
    apb(0, rcio_pkg::OFS_STATUS, 0);
    check("keys", rd[11:0], 12'h1 << (kc * 3 + kr));
    key_on = 1'b0;
    apb(1, rcio_pkg::OFS_CTRL, 32'h082);
    for (i = 0; i < 2; i++) begin
      v = $urandom & 32'h1ff;
      nb = dn;
      driver_full_in <= 1'b1;
      apb(1, rcio_pkg::OFS_DISP, v | (i << 9));
      repeat (40) @(posedge clk_sys);
      check("stalled", dn - nb, 0);
      driver_full_in <= 1'b0;
      for (t = 0; t < 1000 && row_oe != 4'h0; t++) @(posedge clk_sys);
      lim(t, 1000);
      check("display", {dn[7:0] - nb[7:0], ds, dc, dbits}, {8'h8, i ? 2'h1 : 2'h2, v[8], v[7:0]});
    end
    for (i = 0; i < 2; i++) begin
      apb(1, rcio_pkg::OFS_CTRL, 32'h080 | i);
      morse_key_in <= 1'b0;
      repeat (SD * 8) @(posedge clk_sys);
      check("keyed", {tx_key_out, sidetone_enable, power_limit_out}, 3'h7);
      e[0] = tone_out;
      for (t = 0; t < 20 && tone_out === e[0]; t++) @(posedge clk_sys);
      check("tone toggles", t < 20, 1);
      morse_key_in <= 1'b1;
      repeat (SD * 8) @(posedge clk_sys);
      check("released", {tx_key_out, tone_out}, 2'h2);
      for (t = SD * 8; t < 1000 && tx_key_out; t++) @(posedge clk_sys);
      lim(t, 1000);
      check("hang", t > (i ? HL : HS) && t < (i ? HL : HS) + SD * 8, 1);
    end
    // The transmit line loops back to the receiver; a second byte sent while busy must be dropped.
    v = $urandom & 32'hff;
    uq.push_back(v[7:0]);
    apb(1, rcio_pkg::OFS_UART, v);
    apb(1, rcio_pkg::OFS_UART, ~v);
    for (t = 0; t < 100; t++) begin
      apb(0, rcio_pkg::OFS_UART, 0);
      if (rd[8] === 1'b1) break;
    end
    lim(t, 100);
    check("uart rx", rd[7:0], uq.pop_front());
    repeat (300) @(posedge clk_sys);
    apb(0, rcio_pkg::OFS_UART, 0);
    check("uart idle", rd[9:8], 2'h0);
    end_of_test();
  end
endmodule
